// ==== core/spsel_pkg.sv ====
// package: constants and carrier types for the serial port select and spi slave
`default_nettype none
package spsel_pkg;
   localparam int ADDR_W = 13;
   localparam int INSTR_W = 16;
   localparam int BYTE_W = 8;
   localparam logic [3:0] INSTR_LAST = 4'hF;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   localparam int INSTR_RW_BIT = 15;
   localparam logic [ADDR_W-1:0] ADDR_TOP = 13'h1FFF;
   localparam logic [ADDR_W-1:0] ADDR_BOTTOM = 13'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;
   // register offsets
   localparam logic [ADDR_W-1:0] REG_PORT_CFG = 13'h0000;
   localparam logic [ADDR_W-1:0] REG_RDBK_CFG = 13'h0001;
   localparam logic [ADDR_W-1:0] REG_XFER_STROBE = 13'h000F;
   // field positions
   localparam int CFG_LSB_FIRST_A = 1;
   localparam int CFG_LSB_FIRST_B = 6;
   localparam int CFG_ASCEND_A = 2;
   localparam int CFG_ASCEND_B = 5;
   localparam int RDBK_ACTIVE_BIT = 5;
   localparam int XFER_BIT = 0;
   // reset values
   localparam logic [7:0] PORT_CFG_RST = 8'h00;
   localparam logic [7:0] RDBK_CFG_RST = 8'h00;
   localparam logic [7:0] REG_RST = 8'h00;
   // i2c address: fixed upper five bits
   localparam logic [4:0] I2C_ADDR_HI = 5'h15;
   localparam int MEM_DEPTH = 64;
   localparam int MEM_AW = 6;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [1:0] {SPSEL_MODE_SPI, SPSEL_MODE_I2C_A, SPSEL_MODE_I2C_B, SPSEL_MODE_UNDEF} spsel_mode_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] data;
   } spsel_wr_type;
endpackage
`default_nettype wire

// ==== core/spsel_port.sv ====
// serial port select strap capture and spi slave with buffered register file
`timescale 1ns/100ps
`default_nettype none
module spsel_port
   import spsel_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic port_strap_low,
   input wire logic port_strap_high,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic serial_out_line,
   output logic serial_out_oe,
   input wire logic three_wire,
   output logic spi_active,
   output logic [6:0] i2c_slave_addr,
   output logic i2c_addr_undefined,
   output logic update_pulse
);
   logic [1:0] sclk_sync_reg;
   logic [1:0] cs_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic [1:0] strap_lo_sync_reg;
   logic [1:0] strap_hi_sync_reg;
   logic [1:0] wire3_sync_reg;
   logic sclk_prev_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_n_s;
   logic sdi_s;
   logic strap_taken_reg;
   spsel_mode_type mode_reg;

   logic [7:0] port_cfg_reg;
   logic [7:0] rdbk_cfg_reg;
   logic [7:0] buf_mem [MEM_DEPTH];
   logic [7:0] act_mem [MEM_DEPTH];

   typedef enum logic [1:0] {SPSEL_ST_IDLE, SPSEL_ST_INSTR, SPSEL_ST_WRITE, SPSEL_ST_READ} spsel_state_type;
   spsel_state_type state_reg;
   logic [INSTR_W-1:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [7:0] tx_reg;
   logic [2:0] tx_cnt_reg;
   logic lsb_first;
   logic ascend;
   logic [INSTR_W-1:0] shift_next;
   logic [INSTR_W-1:0] instr_word;
   logic [7:0] rx_byte;
   logic [ADDR_W-1:0] addr_step;
   logic [7:0] rd_data;
   logic [ADDR_W-1:0] rd_addr;
   // first address past the implemented register file
   localparam logic [ADDR_W-1:0] MEM_END = ADDR_W'(MEM_DEPTH);

   // two-entry write buffer between spi shifter and register file
   spsel_wr_type wq_mem [BUF_DEPTH];
   logic wq_wptr_reg;
   logic wq_rptr_reg;
   logic [1:0] wq_cnt_reg;
   logic wq_in_valid;
   logic wq_in_ready;
   logic wq_out_valid;
   logic wq_out_ready;
   spsel_wr_type wq_in;
   spsel_wr_type wq_out;

   // pins from another domain, three_wire too: two flops each
   always_ff @(posedge mclk)
   begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      cs_sync_reg <= {cs_sync_reg[0], cs_n};
      sdi_sync_reg <= {sdi_sync_reg[0], sdio_in};
      strap_lo_sync_reg <= {strap_lo_sync_reg[0], port_strap_low};
      strap_hi_sync_reg <= {strap_hi_sync_reg[0], port_strap_high};
      wire3_sync_reg <= {wire3_sync_reg[0], three_wire};
      sclk_prev_reg <= sclk_sync_reg[1];
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
   assign cs_n_s = cs_sync_reg[1];
   assign sdi_s = sdi_sync_reg[1];

   // straps taken once after reset release; fixed until the next reset
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         strap_taken_reg <= 1'b0;
         mode_reg <= SPSEL_MODE_UNDEF;
         spi_active <= 1'b0;
         i2c_slave_addr <= 7'h00;
         i2c_addr_undefined <= 1'b0;
      end
      else if (!strap_taken_reg)
      begin
         // take the straps on the first cycle after release with no sclk edge
         if (sclk_prev_reg == sclk_sync_reg[1])
         begin
            strap_taken_reg <= 1'b1;
            spi_active <= ~strap_hi_sync_reg[1] & ~strap_lo_sync_reg[1];
            i2c_slave_addr <= {I2C_ADDR_HI, strap_hi_sync_reg[1], strap_lo_sync_reg[1]};
            i2c_addr_undefined <= strap_hi_sync_reg[1] & ~strap_lo_sync_reg[1];
            mode_reg <= spsel_mode_type'({strap_hi_sync_reg[1], strap_lo_sync_reg[1]});
         end
      end
   end

   assign lsb_first = port_cfg_reg[CFG_LSB_FIRST_A] & port_cfg_reg[CFG_LSB_FIRST_B];
   assign ascend = port_cfg_reg[CFG_ASCEND_A] & port_cfg_reg[CFG_ASCEND_B];
   // lsb-first shifts in from the top, so the first bit lands at bit 0
   assign shift_next = lsb_first ? {sdi_s, shift_reg[INSTR_W-1:1]} : {shift_reg[INSTR_W-2:0], sdi_s};
   assign instr_word = shift_next;
   assign rx_byte = lsb_first ? shift_next[INSTR_W-1:INSTR_W-BYTE_W] : shift_next[BYTE_W-1:0];
   // wraps at both ends of the address space; the host ends the stream first
   assign addr_step = ascend ? addr_reg + ADDR_ONE : addr_reg - ADDR_ONE;
   assign rd_addr = (state_reg == SPSEL_ST_INSTR) ? instr_word[ADDR_W-1:0] : addr_step;

   // offsets above the file and the strobe read as zero
   always_comb
   begin
      rd_data = REG_RST;
      if (rd_addr == REG_PORT_CFG)
         rd_data = port_cfg_reg;
      else if (rd_addr == REG_RDBK_CFG)
         rd_data = rdbk_cfg_reg;
      else if (rd_addr == REG_XFER_STROBE)
         rd_data = REG_RST;
      else if (rd_addr < MEM_END)
      begin
         if (rdbk_cfg_reg[RDBK_ACTIVE_BIT])
            rd_data = act_mem[rd_addr[MEM_AW-1:0]];
         else
            rd_data = buf_mem[rd_addr[MEM_AW-1:0]];
      end
   end

   // a byte enters the buffer on the rise that completes it
   assign wq_in_valid = sclk_rise && !cs_n_s && state_reg == SPSEL_ST_WRITE && bit_cnt_reg[2:0] == BYTE_LAST;
   assign wq_in.addr = addr_reg;
   assign wq_in.data = rx_byte;

   // serial protocol engine
   // a cs_n rise mid-byte drops the partial byte
   always_ff @(posedge mclk)
   begin
      if (srst || cs_n_s || !spi_active)
      begin
         state_reg <= cs_n_s || !spi_active ? SPSEL_ST_IDLE : SPSEL_ST_INSTR;
         shift_reg <= '0;
         bit_cnt_reg <= '0;
         addr_reg <= ADDR_BOTTOM;
         tx_reg <= REG_RST;
         tx_cnt_reg <= '0;
      end
      else
      begin
         if (state_reg == SPSEL_ST_IDLE)
            state_reg <= SPSEL_ST_INSTR;
         if (sclk_rise)
         begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            case (state_reg)
               SPSEL_ST_INSTR:
                  if (bit_cnt_reg == INSTR_LAST)
                  begin
                     addr_reg <= instr_word[ADDR_W-1:0];
                     bit_cnt_reg <= '0;
                     if (instr_word[INSTR_RW_BIT])
                     begin
                        state_reg <= SPSEL_ST_READ;
                        tx_reg <= rd_data;
                     end
                     else
                        state_reg <= SPSEL_ST_WRITE;
                  end
               SPSEL_ST_WRITE:
                  if (bit_cnt_reg[2:0] == BYTE_LAST && wq_in_ready)
                  begin
                     addr_reg <= addr_step;
                     bit_cnt_reg <= '0;
                  end
               SPSEL_ST_READ:
                  if (bit_cnt_reg[2:0] == BYTE_LAST)
                  begin
                     addr_reg <= addr_step;
                     bit_cnt_reg <= '0;
                  end
               default:
                  state_reg <= SPSEL_ST_IDLE;
            endcase
         end
         // read data changes on the falling edge
         if (sclk_fall && state_reg == SPSEL_ST_READ)
         begin
            if (tx_cnt_reg == BYTE_LAST)
            begin
               tx_cnt_reg <= '0;
               tx_reg <= rd_data;
            end
            else
            begin
               tx_cnt_reg <= tx_cnt_reg + 3'h1;
               tx_reg <= lsb_first ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

   // pins: first bit presented at the falling edge after the instruction
   always_ff @(posedge mclk)
   begin
      if (srst || cs_n_s)
      begin
         sdio_out <= 1'b0;
         sdio_oe <= 1'b0;
         serial_out_line <= 1'b0;
         serial_out_oe <= 1'b0;
      end
      else if (state_reg == SPSEL_ST_READ && sclk_fall)
      begin
         sdio_out <= lsb_first ? tx_reg[0] : tx_reg[7];
         serial_out_line <= lsb_first ? tx_reg[0] : tx_reg[7];
         // oe follows the synchronised three_wire pin
         sdio_oe <= wire3_sync_reg[1];
         serial_out_oe <= ~wire3_sync_reg[1];
      end
      else if (state_reg != SPSEL_ST_READ)
      begin
         sdio_oe <= 1'b0;
         serial_out_oe <= 1'b0;
      end
   end

   // write buffer; the register file drains it every cycle, so it never refuses a byte
   assign wq_in_ready = wq_cnt_reg != 2'(BUF_DEPTH);
   assign wq_out_valid = wq_cnt_reg != 2'h0;
   assign wq_out = wq_mem[wq_rptr_reg];
   assign wq_out_ready = 1'b1;

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         wq_wptr_reg <= 1'b0;
         wq_rptr_reg <= 1'b0;
         wq_cnt_reg <= 2'h0;
      end
      else
      begin
         if (wq_in_valid && wq_in_ready)
         begin
            wq_mem[wq_wptr_reg] <= wq_in;
            wq_wptr_reg <= ~wq_wptr_reg;
         end
         if (wq_out_valid && wq_out_ready)
            wq_rptr_reg <= ~wq_rptr_reg;
         wq_cnt_reg <= wq_cnt_reg + 2'(wq_in_valid && wq_in_ready) - 2'(wq_out_valid && wq_out_ready);
      end
   end

   // register file: config registers act at once, others buffered
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         port_cfg_reg <= PORT_CFG_RST;
         rdbk_cfg_reg <= RDBK_CFG_RST;
         update_pulse <= 1'b0;
      end
      else
      begin
         update_pulse <= 1'b0;
         if (wq_out_valid && wq_out_ready)
         begin
            if (wq_out.addr == REG_PORT_CFG)
               port_cfg_reg <= wq_out.data;
            else if (wq_out.addr == REG_RDBK_CFG)
               rdbk_cfg_reg <= wq_out.data;
            else if (wq_out.addr == REG_XFER_STROBE)
               update_pulse <= wq_out.data[XFER_BIT];
         end
      end
   end

   // buffers start at the default so an unwritten address reads a known byte
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < MEM_DEPTH; i++)
         begin
            buf_mem[i] <= REG_RST;
         end
      end
      else if (wq_out_valid && wq_out_ready && wq_out.addr < MEM_END
               && wq_out.addr != REG_XFER_STROBE)
         buf_mem[wq_out.addr[MEM_AW-1:0]] <= wq_out.data;
   end

   // update bit never stored, so it reads back cleared
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < MEM_DEPTH; i++)
         begin
            act_mem[i] <= REG_RST;
         end
      end
      else if (update_pulse)
         act_mem <= buf_mem;
   end
endmodule
`default_nettype wire

// ==== tb/spsel_host_model.sv ====
// partner: spi host that drives clock, select and data line
`timescale 1ns/100ps
`default_nettype none
module spsel_host_model
(
   input wire logic mclk,
   output logic sclk,
   output logic cs_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic serial_out_line,
   input wire logic serial_out_oe,
   input wire logic three_wire
);
   logic lsb = 1'b0;
   logic host_oe = 1'b0;
   logic host_d = 1'b0;
   logic last_reg = 1'b0;
   // released line toggles so no stale bit can pass for data
   always @(negedge mclk)
      last_reg <= sdio_in;
   assign sdio_in = sdio_oe ? sdio_out : host_oe ? host_d : ~last_reg;
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
   task automatic shift(input int nb, input logic [15:0] w, output logic [15:0] r);
      int k;
      r = 16'h0000;
      for (int i = 0; i < nb; i++)
      begin
         k = lsb ? i : nb - 1 - i;
         host_d = w[k];
         repeat (4) @(negedge mclk);
         sclk = 1'b1;
         r[k] = three_wire ? sdio_in : serial_out_oe ? serial_out_line : ~serial_out_line;
         repeat (4) @(negedge mclk);
         sclk = 1'b0;
      end
   endtask
   task automatic xfer(input logic rw, input logic [14:0] a, input int n, input logic [31:0] wd,
                       output logic [31:0] rq);
      logic [15:0] r;
      rq = 32'h0;
      cs_n = 1'b0;
      host_oe = 1'b1;
      repeat (4) @(negedge mclk);
      shift(16, {rw, a}, r);
      host_oe = !rw;
      for (int i = 0; i < n; i++)
      begin
         shift(8, {8'h00, wd[8*i+:8]}, r);
         rq[8*i+:8] = r[7:0];
      end
      repeat (4) @(negedge mclk);
      cs_n = 1'b1;
      host_oe = 1'b0;
      repeat (8) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// ==== tb/spsel_port_asserts.sv ====
// checker: strap select and spi slave port relations
`timescale 1ns/100ps
`default_nettype none
module spsel_port_asserts
   import spsel_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic port_strap_low,
   input wire logic port_strap_high,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic serial_out_line,
   input wire logic serial_out_oe,
   input wire logic three_wire,
   input wire logic spi_active,
   input wire logic [6:0] i2c_slave_addr,
   input wire logic i2c_addr_undefined,
   input wire logic update_pulse
);
   logic [4:0] rise_cnt_reg;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   sequence sclk_rise;
      !sclk ##1 sclk;
   endsequence
   // raw rises lead the design's synchronised count, so the bound is safe
   always_ff @(posedge mclk)
   begin
      if (srst || $fell(cs_n))
         rise_cnt_reg <= 5'h00;
      else if (!cs_n && $rose(sclk) && rise_cnt_reg != 5'h1F)
         rise_cnt_reg <= rise_cnt_reg + 5'h01;
   end
   a_idle_released: assert property (cs_n [*5] |-> !sdio_oe && !serial_out_oe) else $error("driven while idle");
   a_drive_after_instr: assert property ((sdio_oe || serial_out_oe) |-> rise_cnt_reg >= 5'h10)
      else $error("data driven inside instruction");
   a_wire_so: assert property (three_wire |-> !serial_out_oe) else $error("output pin used in 3-wire");
   a_wire_sdio: assert property (!three_wire |-> !sdio_oe) else $error("data pin driven in 4-wire");
   a_so_hold: assert property (sclk_rise ##0 serial_out_oe |=> $stable(serial_out_line) [*4])
      else $error("output moved after rising edge");
   a_sdio_hold: assert property (sclk_rise ##0 sdio_oe |=> $stable(sdio_out) [*4])
      else $error("data pin moved after rising edge");
   a_spi_straps: assert property (spi_active |-> i2c_slave_addr[1:0] == 2'b00 && !i2c_addr_undefined)
      else $error("spi chosen with strap high");
   a_addr_fixed: assert property (i2c_slave_addr != 7'h00 |-> i2c_slave_addr[6:2] == 5'h15)
      else $error("fixed address bits wrong");
   a_undef_code: assert property (i2c_addr_undefined |-> i2c_slave_addr[1:0] == 2'b10 && !spi_active)
      else $error("undefined flag wrong");
   a_update_single: assert property (update_pulse |=> !update_pulse) else $error("update pulse too long");
   a_mode_fixed: assert property ($changed(spi_active) |-> $past(srst, 7)) else $error("mode moved after start");
endmodule
bind spsel_port spsel_port_asserts spsel_port_asserts_i (.mclk, .srst, .port_strap_low, .port_strap_high, .sclk,
   .cs_n, .sdio_in, .sdio_out, .sdio_oe, .serial_out_line, .serial_out_oe, .three_wire, .spi_active,
   .i2c_slave_addr, .i2c_addr_undefined, .update_pulse);
`default_nettype wire

// ==== tb/spsel_port_tb.sv ====
// testbench: strap select and spi slave scenarios
`timescale 1ns/100ps
`default_nettype none
module spsel_port_tb;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic strap_l = 1'b0;
   logic strap_h = 1'b0;
   logic three_wire = 1'b0;
   logic upd_seen = 1'b0;
   logic [31:0] q;
   int miscompares = 0;
   int n_checks = 0;
   wire logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, serial_out_line, serial_out_oe;
   wire logic spi_active, i2c_addr_undefined, update_pulse;
   wire logic [6:0] i2c_slave_addr;
   always #12.5 mclk = ~mclk;
   always @(posedge mclk)
      if (update_pulse)
         upd_seen <= 1'b1;
   spsel_port spsel_port_i (.mclk(mclk), .srst(srst), .port_strap_low(strap_l), .port_strap_high(strap_h),
      .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .three_wire(three_wire),
      .spi_active(spi_active), .i2c_slave_addr(i2c_slave_addr), .i2c_addr_undefined(i2c_addr_undefined),
      .update_pulse(update_pulse));
   spsel_host_model spsel_host_model_i (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
      .three_wire(three_wire));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
      spsel_host_model_i.xfer(1'b0, a, n, d, q);
   endtask
   task automatic rd(input logic [14:0] a, input int n);
      spsel_host_model_i.xfer(1'b1, a, n, 32'h0, q);
   endtask
   task automatic reboot(input logic h, input logic l);
      @(negedge mclk);
      srst = 1'b1;
      strap_h = h;
      strap_l = l;
      repeat (16) @(negedge mclk);
      srst = 1'b0;
      repeat (8) @(negedge mclk);
   endtask
   task automatic t_straps();
      for (int k = 0; k < 4; k++)
      begin
         reboot(k[1], k[0]);
         check("spi_active", spi_active, k == 0);
         check("i2c_slave_addr", i2c_slave_addr, {5'h15, k[1], k[0]});
         check("i2c_addr_undefined", i2c_addr_undefined, k == 2);
      end
      reboot(1'b0, 1'b0);
      $display("t_straps done");
   endtask
   task automatic t_stream();
      wr(15'h0000, 1, 32'h24);
      wr(15'h0020, 4, 32'h44332211);
      rd(15'h6020, 4);
      check("ascending buffer read", q, 32'h44332211);
      wr(15'h003F, 2, 32'h0077);
      rd(15'h003F, 2);
      check("stream across map end", q, 32'h0077);
      wr(15'h0001, 1, 32'h20);
      rd(15'h0020, 1);
      check("active before update", q, 32'h0);
      check("no update before strobe", upd_seen, 32'h0);
      wr(15'h000F, 1, 32'h01);
      check("update pulse", upd_seen, 32'h1);
      rd(15'h0020, 4);
      check("active after update", q, 32'h44332211);
      rd(15'h000F, 1);
      check("update bit cleared", q, 32'h0);
      wr(15'h0100, 1, 32'h5A);
      rd(15'h0100, 1);
      check("unmapped read", q, 32'h0);
      $display("t_stream done");
   endtask
   task automatic t_descend();
      wr(15'h0000, 1, 32'h00);
      wr(15'h0001, 1, 32'h00);
      wr(15'h0031, 2, 32'hBBAA);
      rd(15'h0030, 1);
      check("descending write", q, 32'hBB);
      rd(15'h0031, 2);
      check("descending read", q, 32'hBBAA);
      $display("t_descend done");
   endtask
   task automatic t_three();
      three_wire = 1'b1;
      rd(15'h0031, 2);
      check("three wire read", q, 32'hBBAA);
      three_wire = 1'b0;
      $display("t_three done");
   endtask
   task automatic t_lsb();
      wr(15'h0000, 1, 32'h66);
      spsel_host_model_i.lsb = 1'b1;
      wr(15'h0025, 1, 32'h1E);
      rd(15'h0025, 1);
      check("lsb first", q, 32'h1E);
      $display("t_lsb done");
   endtask
   task automatic end_of_test();
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      t_straps();
      t_stream();
      t_descend();
      t_three();
      t_lsb();
      end_of_test();
   end
   // some twenty transfers of about 5 to 10 us each, with wide margin
   initial
   begin
      #2000000;
      miscompares++;
      end_of_test();
   end
endmodule
`default_nettype wire
